// ### logic/atsm_regs.sv
// atsm_regs: threshold, status and service-request trigger registers with the request line
// Operation
// - an oversized threshold write stores the largest permitted value
// - out-of-range write: saturate and answer OK, no execution error
// - fatal thermal threshold holds unsigned hundredths of a degree
// - registers load defaults at start, save command replaces those defaults; here sys_rst reloads the parameter defaults, fwRestart the saved copy
// - failed read answers execution error, fault code, zero data
// - failed mask write answers execution error, fault code, zero data
// - each mask bit selects the status flag at the same position
// - mask one enables, mask zero blocks that flag
// - mask layout: disable, warnings, common flags, fatals
// - no request from frequency, thermal or power faults while unlocked
// - case temperature fault requests whenever thermal bit is enabled
// - trigger mask defaults to all thirteen flags enabled
// - command errors are returned in that command's own response
// - background execution failure sets latched exec error flag
// - line releases on mask rewrite or clearing the enabled flags
// - thermal thresholds bound deviation before fatal condition, hundredths
// - writing one to a latched flag clears it
// - restart flag reads one after any restart until cleared
`timescale 1ns/100ps
module atsm_regs
    import atsm_pkg::*;
#(
    parameter logic [15:0] FREQ_MAX   = FREQ_MAX_DEF,
    parameter logic [15:0] THERM_MAX  = THERM_MAX_DEF,
    parameter logic [15:0] FREQ_F_DEF = FREQ_FATAL_DEF,
    parameter logic [15:0] FREQ_W_DEF = FREQ_WARNING_DEF,
    parameter logic [15:0] THRM_F_DEF = THERM_FATAL_DEF,
    parameter logic [15:0] THRM_W_DEF = THERM_WARNING_DEF,
    parameter logic [15:0] MASK_DEF   = SRQ_MASK_DEF
) (
    input  wire logic      clk,
    input  wire logic      sys_rst,
    input  wire atsm_cmd_t cmd,
    input  wire logic [3:0] fatalEvent,
    input  wire logic [3:0] warnEvent,
    input  wire logic      bgExecFail,
    input  wire logic      commErrEvent,
    input  wire logic      ifaceResetEvent,
    input  wire logic      fwRestart,
    input  wire logic      saveConfig,
    input  wire logic      laserLocked,
    input  wire logic      caseTempFault,
    input  wire logic      disable_flag,
    output atsm_rsp_t      rsp,
    output logic           service_request_n,
    output logic [15:0]    freqFatalTh,
    output logic [15:0]    freqWarnTh,
    output logic [15:0]    thermFatalTh,
    output logic [15:0]    thermWarnTh
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (FREQ_F_DEF > FREQ_MAX || FREQ_W_DEF > FREQ_MAX) begin : g_chk_freq
        $error("frequency default above its maximum");
    end
    if (THRM_F_DEF > THERM_MAX || THRM_W_DEF > THERM_MAX) begin : g_chk_therm
        $error("thermal default above its maximum");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // clamp a written value to the usable range
    function automatic logic [15:0] atsm_sat(input logic [15:0] v, input logic [15:0] mx);
        atsm_sat = (v > mx) ? mx : v;
    endfunction : atsm_sat

    // drop lock-dependent faults while unlocked; case temperature bypasses lock
    function automatic logic [3:0] atsm_qual(input logic [3:0] x, input logic lk,
                                             input logic caseT);
        logic [3:0] q;
        q = lk ? x : (x & 4'h8);
        q[SUB_THERMAL] = (x[SUB_THERMAL] & lk) | caseT;
        atsm_qual = q;
    endfunction : atsm_qual

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] freqF_reg, freqW_reg, thrmF_reg, thrmW_reg, mask_reg;
    logic [15:0] freqFSave_reg, freqWSave_reg, thrmFSave_reg, thrmWSave_reg, maskSave_reg;
    logic [3:0]  fatLat_reg, warnLat_reg, common_reg;
    logic [15:0] freqF_next, freqW_next, thrmF_next, thrmW_next, mask_next;
    logic [3:0]  fatLat_next, warnLat_next, common_next;
    atsm_rsp_t   rsp_reg, rsp_next;
    logic        srqN_reg, srqN_next;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire logic        take      = cmd.valid;
    wire logic        faulted   = take && (cmd.fault != ATSM_EC_OK);
    wire logic        hitFstat  = cmd.addr == REG_FATAL_STATUS;
    wire logic        hitWstat  = cmd.addr == REG_WARNING_STATUS;
    wire logic        hitFreqF  = cmd.addr == REG_FREQ_FATAL;
    wire logic        hitFreqW  = cmd.addr == REG_FREQ_WARNING;
    wire logic        hitThrmF  = cmd.addr == REG_THERMAL_FATAL;
    wire logic        hitThrmW  = cmd.addr == REG_THERMAL_WARNING;
    wire logic        hitMask   = cmd.addr == REG_SRQ_MASK;
    wire logic        mapped    = hitFstat | hitWstat | hitFreqF | hitFreqW
                                | hitThrmF | hitThrmW | hitMask;
    wire logic        wrOk      = take && cmd.write && !faulted && mapped;
    wire logic [15:0] freqSat   = atsm_sat(cmd.data, FREQ_MAX);
    wire logic [15:0] thrmSat   = atsm_sat(cmd.data, THERM_MAX);

    // write-one clears for latched status bits
    wire logic [3:0]  clrFat    = (wrOk && hitFstat) ? cmd.data[3:0] : 4'h0;
    wire logic [3:0]  clrWarn   = (wrOk && hitWstat) ? cmd.data[3:0] : 4'h0;
    wire logic [3:0]  clrCom    = (wrOk && (hitFstat || hitWstat)) ? cmd.data[7:4] : 4'h0;

    // ------------------------------------------------------------
    // next values of the stored registers
    // ------------------------------------------------------------
    // saturate, no error raised
    assign freqF_next = fwRestart ? freqFSave_reg : ((wrOk && hitFreqF) ? freqSat : freqF_reg);
    assign freqW_next = fwRestart ? freqWSave_reg : ((wrOk && hitFreqW) ? freqSat : freqW_reg);
    assign thrmF_next = fwRestart ? thrmFSave_reg : ((wrOk && hitThrmF) ? thrmSat : thrmF_reg);
    assign thrmW_next = fwRestart ? thrmWSave_reg : ((wrOk && hitThrmW) ? thrmSat : thrmW_reg);
    assign mask_next  = fwRestart ? maskSave_reg
                      : ((wrOk && hitMask) ? (cmd.data & MASK_VALID) : mask_reg);

    // write-one clear, an event in the same cycle wins
    assign fatLat_next  = (fatLat_reg & ~clrFat) | fatalEvent;
    assign warnLat_next = (warnLat_reg & ~clrWarn) | warnEvent;
    // background failure latches exec error; restart latches flag
    assign common_next  = (common_reg & ~clrCom)
                        | {bgExecFail, commErrEvent, fwRestart, ifaceResetEvent | fwRestart};

    // ------------------------------------------------------------
    // service request, computed from next values
    // ------------------------------------------------------------
    // lock qualification of fatal and warning nibbles
    wire logic [15:0] flagsQ = {3'h0, disable_flag,
                                atsm_qual(warnLat_next, laserLocked, caseTempFault),
                                common_next,
                                atsm_qual(fatLat_next, laserLocked, caseTempFault)};
    // line low on any enabled flag, released otherwise
    assign srqN_next = ~|(flagsQ & mask_next);

    // ------------------------------------------------------------
    // response
    // ------------------------------------------------------------
    wire logic [15:0] rdData = hitFstat ? {8'h00, common_reg, fatLat_reg}
                             : hitWstat ? {8'h00, common_reg, warnLat_reg}
                             : hitFreqF ? freqF_reg
                             : hitFreqW ? freqW_reg
                             : hitThrmF ? thrmF_reg
                             : hitThrmW ? thrmW_reg
                             : hitMask  ? mask_reg
                             : 16'h0000;
    wire logic [15:0] wrEcho = hitFreqF || hitFreqW ? freqSat
                             : hitThrmF || hitThrmW ? thrmSat
                             : hitMask  ? (cmd.data & MASK_VALID)
                             : cmd.data;
    // errors of this command answered in its own response
    always_comb begin
        rsp_next.valid   = take;
        rsp_next.status  = ATSM_ST_OK;
        rsp_next.errCode = ATSM_EC_OK;
        rsp_next.data    = cmd.write ? wrEcho : rdData;
        if (faulted) begin
            rsp_next.status  = ATSM_ST_XE;
            rsp_next.errCode = cmd.fault;
            rsp_next.data    = 16'h0000;
        end else if (!mapped) begin
            rsp_next.status  = ATSM_ST_XE;
            rsp_next.errCode = ATSM_EC_EXEC_FAILURE;
            rsp_next.data    = 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // live registers
    // ------------------------------------------------------------
    // defaults at reset, restart flags set at reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            freqF_reg   <= FREQ_F_DEF;
            freqW_reg   <= FREQ_W_DEF;
            thrmF_reg   <= THRM_F_DEF;
            thrmW_reg   <= THRM_W_DEF;
            mask_reg    <= MASK_DEF;
            fatLat_reg  <= 4'h0;
            warnLat_reg <= 4'h0;
            common_reg  <= COMMON_RST;
            rsp_reg     <= '0;
            srqN_reg    <= 1'b1;
        end else begin
            freqF_reg   <= freqF_next;
            freqW_reg   <= freqW_next;
            thrmF_reg   <= thrmF_next;
            thrmW_reg   <= thrmW_next;
            mask_reg    <= mask_next;
            fatLat_reg  <= fatLat_next;
            warnLat_reg <= warnLat_next;
            common_reg  <= common_next;
            rsp_reg     <= rsp_next;
            srqN_reg    <= srqN_next;
        end
    end

    // ------------------------------------------------------------
    // saved configuration
    // ------------------------------------------------------------
    // save replaces the defaults a later restart reloads; the copy is
    // volatile here, a real part backs it with non-volatile storage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            freqFSave_reg <= FREQ_F_DEF;
            freqWSave_reg <= FREQ_W_DEF;
            thrmFSave_reg <= THRM_F_DEF;
            thrmWSave_reg <= THRM_W_DEF;
            maskSave_reg  <= MASK_DEF;
        end else if (saveConfig) begin
            freqFSave_reg <= freqF_reg;
            freqWSave_reg <= freqW_reg;
            thrmFSave_reg <= thrmF_reg;
            thrmWSave_reg <= thrmW_reg;
            maskSave_reg  <= mask_reg;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rsp               = rsp_reg;
    assign service_request_n = srqN_reg;
    assign freqFatalTh       = freqF_reg;
    assign freqWarnTh        = freqW_reg;
    assign thermFatalTh      = thrmF_reg;
    assign thermWarnTh       = thrmW_reg;

endmodule : atsm_regs

// ### logic/atsm_pkg.sv
// atsm_pkg: register map, field layout, reset values and carriers for the alarm threshold bank
package atsm_pkg;

    // ------------------------------------------------------------
    // register numbers
    // ------------------------------------------------------------
    localparam logic [7:0] REG_FATAL_STATUS     = 8'h20;
    localparam logic [7:0] REG_WARNING_STATUS   = 8'h21;
    localparam logic [7:0] REG_FREQ_FATAL       = 8'h24;
    localparam logic [7:0] REG_FREQ_WARNING     = 8'h25;
    localparam logic [7:0] REG_THERMAL_FATAL    = 8'h26;
    localparam logic [7:0] REG_THERMAL_WARNING  = 8'h27;
    localparam logic [7:0] REG_SRQ_MASK         = 8'h28;

    // ------------------------------------------------------------
    // flag layout of the mask; status registers use bits 7:0 with their own nibble at 3:0
    // ------------------------------------------------------------
    localparam int          FLD_FATAL_LSB   = 0;   // bits 3:0 latched fatals
    localparam int          FLD_COMMON_LSB  = 4;   // bits 7:4 exec, comm, restart, iface reset
    localparam int          FLD_WARN_LSB    = 8;   // bits 11:8 latched warnings
    localparam int          FLD_DISABLE     = 12;  // bit 12 output disabled
    localparam int          SUB_VENDOR      = 3;   // within a nibble
    localparam int          SUB_FREQ        = 2;
    localparam int          SUB_THERMAL     = 1;
    localparam int          SUB_POWER       = 0;
    localparam int          COM_EXEC        = 3;   // within common nibble
    localparam int          COM_COMM        = 2;
    localparam int          COM_RESTART     = 1;
    localparam int          COM_IFACE       = 0;
    localparam logic [15:0] MASK_VALID      = 16'h1fff;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [15:0] FREQ_FATAL_DEF    = 16'h0064;
    localparam logic [15:0] FREQ_WARNING_DEF  = 16'h0032;
    localparam logic [15:0] THERM_FATAL_DEF   = 16'h01f4;
    localparam logic [15:0] THERM_WARNING_DEF = 16'h00c8;
    localparam logic [15:0] FREQ_MAX_DEF      = 16'h7fff;
    localparam logic [15:0] THERM_MAX_DEF     = 16'h7fff;
    localparam logic [15:0] SRQ_MASK_DEF      = 16'h1fff;
    localparam logic [3:0]  COMMON_RST        = 4'h3;   // restart and iface reset set

    // ------------------------------------------------------------
    // response codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ATSM_ST_OK = 2'b00,
        ATSM_ST_XE = 2'b01
    } atsm_status_t;

    typedef enum logic [3:0] {
        ATSM_EC_OK              = 4'h0,
        ATSM_EC_NOT_WRITEABLE   = 4'h1,
        ATSM_EC_RANGE_ERROR     = 4'h2,
        ATSM_EC_CMD_IN_PROGRESS = 4'h3,
        ATSM_EC_INVALID_IFACE   = 4'h4,
        ATSM_EC_EXEC_FAILURE    = 4'h5,
        ATSM_EC_VENDOR_ERROR    = 4'h6
    } atsm_err_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [15:0] data;
        atsm_err_t   fault;   // front-end failure, OK when none
    } atsm_cmd_t;

    typedef struct packed {
        logic         valid;
        atsm_status_t status;
        atsm_err_t    errCode;
        logic [15:0]  data;
    } atsm_rsp_t;

endpackage : atsm_pkg

// ### verification/atsm_regs_props.sv
// atsm_regs_props: port-level timing and value checks for the alarm threshold bank
`timescale 1ns/100ps
module atsm_regs_props
    import atsm_pkg::*;
#(
    parameter logic [15:0] FREQ_MAX  = FREQ_MAX_DEF,
    parameter logic [15:0] THERM_MAX = THERM_MAX_DEF
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire atsm_cmd_t   cmd,
    input wire logic        fwRestart,
    input wire atsm_rsp_t   rsp,
    input wire logic        service_request_n,
    input wire logic [15:0] freqFatalTh,
    input wire logic [15:0] freqWarnTh,
    input wire logic [15:0] thermFatalTh
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------
    // decode of accepted writes
    // ------------------------------------------------------------
    // a front-end fault blocks every register write, so only clean writes count
    wire logic okWr   = cmd.valid && cmd.write && (cmd.fault == ATSM_EC_OK);
    wire logic mapped = cmd.addr inside {8'h20, 8'h21, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28};

    property p_answer; cmd.valid |=> rsp.valid; endproperty
    a_answer: assert property (p_answer) else $error("no answer after command");
    property p_quiet; !cmd.valid |=> !rsp.valid; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without command");
    property p_fault;
        cmd.valid && cmd.fault != ATSM_EC_OK |=> rsp.status == ATSM_ST_XE &&
            rsp.errCode == $past(cmd.fault) && rsp.data == 16'h0000;
    endproperty
    a_fault: assert property (p_fault) else $error("failed command answer wrong");
    property p_unmapped;
        cmd.valid && cmd.fault == ATSM_EC_OK && !mapped |=> rsp.status == ATSM_ST_XE &&
            rsp.errCode == ATSM_EC_EXEC_FAILURE && rsp.data == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access answer wrong");
    property p_saturate;
        okWr && cmd.addr == REG_FREQ_FATAL && cmd.data > FREQ_MAX |=>
            freqFatalTh == FREQ_MAX && rsp.status == ATSM_ST_OK && rsp.data == FREQ_MAX;
    endproperty
    a_saturate: assert property (p_saturate) else $error("oversized write not clipped");
    property p_store;
        okWr && cmd.addr == REG_THERMAL_FATAL && cmd.data <= THERM_MAX |=>
            thermFatalTh == $past(cmd.data);
    endproperty
    a_store: assert property (p_store) else $error("thermal limit not stored");
    property p_warn_echo;
        okWr && cmd.addr == REG_FREQ_WARNING && cmd.data <= FREQ_MAX |=>
            freqWarnTh == $past(cmd.data) && rsp.data == $past(cmd.data);
    endproperty
    a_warn_echo: assert property (p_warn_echo) else $error("warning limit not echoed");
    property p_mask_echo;
        okWr && cmd.addr == REG_SRQ_MASK |=> rsp.data == ($past(cmd.data) & MASK_VALID);
    endproperty
    a_mask_echo: assert property (p_mask_echo) else $error("mask layout wrong");
    property p_mask_zero;
        okWr && cmd.addr == REG_SRQ_MASK && cmd.data == 16'h0000 |=> rsp.valid && service_request_n;
    endproperty
    a_mask_zero: assert property (p_mask_zero) else $error("line held with empty mask");
    property p_hold;
        !(cmd.valid && cmd.write) && !fwRestart |=> freqFatalTh == $past(freqFatalTh);
    endproperty
    a_hold: assert property (p_hold) else $error("limit changed without write");

    c_clip: cover property (okWr && cmd.addr == REG_FREQ_FATAL && cmd.data > FREQ_MAX);
    c_low: cover property ($fell(service_request_n));
    c_rel: cover property ($rose(service_request_n));
endmodule : atsm_regs_props

bind atsm_regs atsm_regs_props #(.FREQ_MAX(FREQ_MAX), .THERM_MAX(THERM_MAX)) chk (
    .clk(clk), .sys_rst(sys_rst), .cmd(cmd), .fwRestart(fwRestart), .rsp(rsp),
    .service_request_n(service_request_n), .freqFatalTh(freqFatalTh),
    .freqWarnTh(freqWarnTh), .thermFatalTh(thermFatalTh));

// ### verification/atsm_host.sv
// atsm_host: host controller model issuing commands and taking answers
`timescale 1ns/100ps
module atsm_host
    import atsm_pkg::*;
(
    input  wire logic      clk,
    output atsm_cmd_t      cmd,
    input  wire atsm_rsp_t rsp
);
    initial cmd = '{1'b0, 1'b0, 8'h00, 16'h0000, ATSM_EC_OK};
    // one strobe edge; the answer stands one cycle, so take it right after that edge
    task automatic send(input logic wr, input logic [7:0] a, input logic [15:0] d,
                        input atsm_err_t f, output atsm_rsp_t r);
        @(posedge clk);
        #1 cmd = '{1'b1, wr, a, d, f};
        @(posedge clk);
        #1 r = rsp;
        // idle write, address and data fields scrambled so nothing can lean on stale values
        cmd = '{1'b0, ~wr, ~a, ~d, f};
    endtask : send
endmodule : atsm_host

// ### verification/atsm_regs_bench.sv
// atsm_regs_bench: self-checking bench for the alarm threshold bank
`timescale 1ns/100ps
`define CHK(a, e) begin cmpCount++; if ((a) !== (e)) begin errTotal++; \
    $display("mismatch at %0t got %h exp %h", $time, a, e); end end
module atsm_regs_bench
    import atsm_pkg::*;
;
    typedef struct packed {
        logic wr; logic [7:0] a; logic [15:0] d; atsm_err_t f;
        atsm_status_t st; atsm_err_t ec; logic [15:0] ex;
    } atsm_row_t;
    localparam atsm_status_t OK = ATSM_ST_OK;
    localparam atsm_status_t XE = ATSM_ST_XE;
    localparam atsm_err_t    NE = ATSM_EC_OK;
    logic clk = 0, sys_rst = 1, laserLocked = 0, caseTempFault = 0;
    logic bgExecFail = 0, fwRestart = 0, saveConfig = 0, commErrEvent = 0, disableFlag = 0;
    logic [3:0] fatalEvent = 4'h0;
    logic service_request_n;
    logic [15:0] freqFatalTh, thermWarnTh;
    atsm_cmd_t cmd;
    atsm_rsp_t rsp, got;
    int errTotal = 0, cmpCount = 0, cycles = 0;
    atsm_row_t rows [16];

    always #5 clk = ~clk;
    atsm_host host (.clk(clk), .cmd(cmd), .rsp(rsp));
    atsm_regs uut (.clk(clk), .sys_rst(sys_rst), .cmd(cmd), .fatalEvent(fatalEvent),
        .warnEvent(fatalEvent), .bgExecFail(bgExecFail), .commErrEvent(commErrEvent),
        .ifaceResetEvent(1'b0), .fwRestart(fwRestart), .saveConfig(saveConfig),
        .laserLocked(laserLocked), .caseTempFault(caseTempFault), .disable_flag(disableFlag),
        .rsp(rsp), .service_request_n(service_request_n), .freqFatalTh(freqFatalTh),
        .freqWarnTh(), .thermFatalTh(), .thermWarnTh(thermWarnTh));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize

    // hang guard: the whole sequence needs under a hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            errTotal++;
            summarize();
        end
    end

    initial begin
        rows = '{'{0, 8'h24, 16'h0, NE, OK, NE, 16'h0064},
            '{0, 8'h27, 16'h0, NE, OK, NE, 16'h00c8},
            '{0, 8'h28, 16'h0, NE, OK, NE, 16'h1fff},
            '{0, 8'h20, 16'h0, NE, OK, NE, 16'h0030},
            '{1, 8'h24, 16'hffff, NE, OK, NE, 16'h7fff},
            '{1, 8'h25, 16'h0010, NE, OK, NE, 16'h0010},
            '{1, 8'h26, 16'h1234, NE, OK, NE, 16'h1234},
            '{0, 8'h26, 16'h0, NE, OK, NE, 16'h1234},
            '{1, 8'h27, 16'h9000, NE, OK, NE, 16'h7fff},
            '{1, 8'h28, 16'hffff, NE, OK, NE, 16'h1fff},
            '{0, 8'h22, 16'h0, NE, XE, ATSM_EC_EXEC_FAILURE, 16'h0},
            '{1, 8'h28, 16'h0, ATSM_EC_NOT_WRITEABLE, XE, ATSM_EC_NOT_WRITEABLE, 16'h0},
            '{0, 8'h24, 16'h0, ATSM_EC_CMD_IN_PROGRESS, XE, ATSM_EC_CMD_IN_PROGRESS, 16'h0},
            '{0, 8'h25, 16'h0, ATSM_EC_INVALID_IFACE, XE, ATSM_EC_INVALID_IFACE, 16'h0},
            '{1, 8'h26, 16'h1, ATSM_EC_VENDOR_ERROR, XE, ATSM_EC_VENDOR_ERROR, 16'h0},
            '{0, 8'h28, 16'h0, NE, OK, NE, 16'h1fff}};
        tick(6);
        sys_rst = 0;
        foreach (rows[i]) begin
            host.send(rows[i].wr, rows[i].a, rows[i].d, rows[i].f, got);
            `CHK({got.valid, got.status, got.errCode, got.data}, {1'b1, rows[i].st, rows[i].ec, rows[i].ex})
        end
        `CHK(service_request_n, 1'b0)
        host.send(1, REG_FATAL_STATUS, 16'h0030, NE, got);
        tick(1);
        `CHK(service_request_n, 1'b1)
        // lock qualification then mask release
        host.send(1, REG_SRQ_MASK, 16'h0004, NE, got);
        fatalEvent = 4'h4;
        tick(1);
        fatalEvent = 4'h0;
        tick(1);
        `CHK(service_request_n, 1'b1)
        laserLocked = 1;
        tick(2);
        `CHK(service_request_n, 1'b0)
        host.send(1, REG_SRQ_MASK, 16'h0000, NE, got);
        `CHK(service_request_n, 1'b1)
        host.send(1, REG_SRQ_MASK, 16'h0004, NE, got);
        host.send(1, REG_FATAL_STATUS, 16'h0004, NE, got);
        tick(1);
        `CHK(service_request_n, 1'b1)
        // case temperature ignores lock state
        laserLocked = 0;
        host.send(1, REG_SRQ_MASK, 16'h0200, NE, got);
        caseTempFault = 1;
        tick(2);
        `CHK(service_request_n, 1'b0)
        caseTempFault = 0;
        host.send(1, REG_SRQ_MASK, 16'h0080, NE, got);
        bgExecFail = 1;
        tick(1);
        bgExecFail = 0;
        tick(1);
        `CHK(service_request_n, 1'b0)
        host.send(0, REG_FATAL_STATUS, 16'h0, NE, got);
        `CHK(got.data, 16'h0080)
        // communication error and disable flags reach the line through their mask bits
        host.send(1, REG_SRQ_MASK, 16'h1040, NE, got);
        commErrEvent = 1;
        tick(1);
        commErrEvent = 0;
        tick(1);
        `CHK(service_request_n, 1'b0)
        host.send(1, REG_FATAL_STATUS, 16'h0040, NE, got);
        tick(1);
        `CHK(service_request_n, 1'b1)
        disableFlag = 1;
        tick(2);
        `CHK(service_request_n, 1'b0)
        disableFlag = 0;
        // saved copy survives a restart, live value does not
        host.send(1, REG_FREQ_FATAL, 16'h0100, NE, got);
        saveConfig = 1;
        tick(1);
        saveConfig = 0;
        host.send(1, REG_FREQ_FATAL, 16'h0005, NE, got);
        fwRestart = 1;
        tick(1);
        fwRestart = 0;
        host.send(0, REG_FREQ_FATAL, 16'h0, NE, got);
        `CHK(got.data, 16'h0100)
        // warning events share the fatal pulse here, so warning bit 2 is still latched
        host.send(0, REG_WARNING_STATUS, 16'h0, NE, got);
        `CHK(got.data, 16'h00b4)
        `CHK(thermWarnTh, 16'h7fff)
        sys_rst = 1;
        tick(2);
        sys_rst = 0;
        `CHK(freqFatalTh, 16'h0064)
        `CHK(thermWarnTh, 16'h00c8)
        // restart flag comes back with reset and the default mask enables it
        tick(1);
        `CHK(service_request_n, 1'b0)
        summarize();
    end
endmodule : atsm_regs_bench
